// ===== rtl/rltm_cfg.svh
// Offsets, field positions, codes, sweep limit, test power and dwell of the relink and test mode controller
// Operation
// - Reconfigure both ends whenever link establishes
// - Force-reconfiguration bit 4 forces relink
// - Listed settings apply only after reconfiguration
// - Slave port disabled only by EEPROM status bit6
// - Hop table never sent over link
// - Link-locate sends sampling rate automatically
// - Link-locate sends receiver mode automatically
// - Receiver input pins sent in locate, streaming
// - Remote execute reaches receiver master interfaces
// - Write test registers, then bit 4, restart
// - Test mode left only by reset
// - Test registers reached only through slave port
// - EEPROM data held low aborts read
// - Codes 0x63 single, 0x73 sweep test
// - Sweep 2400 to 2480 MHz, 1 MHz steps
// - Test channel bit 7 selects TX/RX
// - Bits 6:0 give single-channel number
// - Test mode forces 0 dBm power
// - Receiver transfer status excludes receiver mode
// - Update 0x01 sends, clears 0x00 on success
// - Update reads 0x02 after failed transfer
`ifndef RLTM_CFG_SVH
`define RLTM_CFG_SVH
`define RLTM_OFS_TEST_CODE 8'h7E
`define RLTM_OFS_TEST_CHAN 8'h7F
`define RLTM_OFS_LINK_MODE 8'h10
`define RLTM_OFS_TX_XFER 8'h5B
`define RLTM_OFS_LNK_XFER 8'h3E
`define RLTM_OFS_RX_XFER 8'h4B
`define RLTM_OFS_REMOTE_EXEC 8'h20
`define RLTM_OFS_POWER 8'h11
`define RLTM_OFS_STATUS 8'h12
`define RLTM_OFS_ADDR_BYTE_0 8'h07
`define RLTM_OFS_ADDR_BYTE_1 8'h08
`define RLTM_OFS_ADDR_BYTE_2 8'h09
`define RLTM_OFS_ADDR_BYTE_3 8'h0A
`define RLTM_OFS_ADDR_BYTE_4 8'h0B
`define RLTM_OFS_HOP_COUNT 8'h0C
`define RLTM_OFS_ACT_COUNT 8'h0D
`define RLTM_BIT_FORCE_RECONF 4
`define RLTM_BIT_SLAVE_OFF 6
`define RLTM_BIT_TEST_DIR 7
`define RLTM_CODE_SINGLE 8'h63
`define RLTM_CODE_SWEEP 8'h73
`define RLTM_SWEEP_LAST 7'h50
`define RLTM_XFER_IDLE_OK 8'h00
`define RLTM_XFER_BUSY 8'h01
`define RLTM_XFER_FAIL 8'h02
`define RLTM_POWER_TEST 2'h3
`define RLTM_DWELL_CYCLES 16'h0064
`endif

// ===== rtl/rltm_pkg.sv
// Types of the relink and test mode controller
package rltm_pkg;
  typedef enum logic [4:0] {
    RLTM_ST_LOCATE = 5'b00001,
    RLTM_ST_STREAM = 5'b00010,
    RLTM_ST_RELINK = 5'b00100,
    RLTM_ST_TEST = 5'b01000,
    RLTM_ST_HOLD = 5'b10000
  } rltm_state_t;
  typedef struct packed {
    logic en;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rltm_req_t;
  typedef struct packed {
    logic [7:0] tx_status;
    logic [7:0] tx_format;
    logic [7:0] tx_mode;
    logic [7:0] i2s_in;
    logic [7:0] tx_latency;
    logic [7:0] rx_mode;
    logic [7:0] i2s_out;
    logic [7:0] test_code;
    logic [7:0] test_chan;
  } rltm_cfg_t;
  typedef struct packed {
    logic [7:0] q;
    logic pend;
  } rltm_xfer_t;
endpackage

// ===== rtl/rltm_xfer_slot.sv
// One transfer-update register: request, busy, success and failure codes
`timescale 1ns/1ns
`default_nettype none
`include "rltm_cfg.svh"
module rltm_xfer_slot
  import rltm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic done_ok,
  input wire logic done_fail,
  output logic [7:0] value,
  output logic start
);
  rltm_xfer_t s_q, s_d;
  // Host request sets busy, link success returns idle code, link failure the fail code
  always_comb begin
    s_d = s_q;
    s_d.pend = 1'b0;
    if (s_q.q == `RLTM_XFER_BUSY && done_ok) begin
      s_d.q = `RLTM_XFER_IDLE_OK;
    end else if (s_q.q == `RLTM_XFER_BUSY && done_fail) begin
      s_d.q = `RLTM_XFER_FAIL;
    end
    if (wr_en && wdata == `RLTM_XFER_BUSY && s_q.q != `RLTM_XFER_BUSY) begin
      s_d.q = `RLTM_XFER_BUSY;
      s_d.pend = 1'b1;
    end
  end
  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign value = s_q.q;
  assign start = s_q.pend;
  AST_FAIL_CODE: assert property (@(posedge clk) disable iff (reset)
    (s_q.q == `RLTM_XFER_BUSY && done_fail && !done_ok) |=> s_q.q == `RLTM_XFER_FAIL)
    else $error("failed transfer not reported");
  AST_OK_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (s_q.q == `RLTM_XFER_BUSY && done_ok && !wr_en) |=> s_q.q == `RLTM_XFER_IDLE_OK)
    else $error("update register not cleared");
endmodule
`default_nettype wire

// ===== rtl/rltm_ctrl.sv
// Relink, deferred configuration, link-locate exchange and test mode controller
`timescale 1ns/1ns
`default_nettype none
`include "rltm_cfg.svh"
module rltm_ctrl
  import rltm_pkg::*;
#(
  parameter int DWELL = 100
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic is_transmitter,
  input wire logic eeprom_present,
  input wire logic eeprom_data,
  input wire logic eeprom_slave_off,
  input wire logic eeprom_done,
  input wire logic link_up,
  input wire logic link_done_ok,
  input wire logic link_done_fail,
  input wire logic [3:0] gpio_in,
  input wire logic [7:0] sample_rate,
  input wire rltm_req_t req,
  input wire logic [7:0] remote_rdata,
  input wire logic remote_rvalid,
  output logic [7:0] rdata,
  output logic slave_enable,
  output logic relink_req,
  output logic reconfig_pulse,
  output logic test_active,
  output logic test_tx_dir,
  output logic test_sweep,
  output logic [6:0] rf_channel,
  output logic [1:0] rf_power,
  output logic [7:0] send_sample_rate,
  output logic [7:0] send_rx_mode,
  output logic send_locate_info,
  output logic [3:0] send_gpio_state,
  output logic send_gpio_valid,
  output logic [7:0] remote_exec_wdata,
  output logic remote_exec_start,
  output logic [1:0] xfer_start,
  output logic [2:0] xfer_slot_start,
  output logic [7:0] live_rx_mode,
  output logic [7:0] live_i2s_out,
  output logic [7:0] live_tx_format
);
  typedef struct packed {
    rltm_state_t st;
    rltm_cfg_t shadow;
    rltm_cfg_t live;
    logic [7:0] link_mode;
    logic [7:0] power;
    logic [7:0] remote_rd;
    logic [7:0] rdata;
    logic slave_off;
    logic strap_done;
    logic test_latched;
    logic [6:0] chan;
    logic [15:0] dwell;
    logic [1:0] rf_power;
    logic [3:0] gpio_s1;
    logic [3:0] gpio_s2;
    logic [3:0] gpio_out;
    logic gpio_valid;
    logic locate;
    logic relink;
    logic reconf;
    logic exec_start;
    logic [7:0] exec_wdata;
    logic [1:0] eed_s;
    logic [1:0] link_s;
    logic [1:0] sync_fill;
    // Deferred link address bytes and channel counts, shadow and applied copies
    logic [4:0][7:0] addr_shadow;
    logic [4:0][7:0] addr_live;
    logic [7:0] hop_cnt_shadow;
    logic [7:0] hop_cnt_live;
    logic [7:0] act_cnt_shadow;
    logic [7:0] act_cnt_live;
  } rltm_state_all_t;
  localparam logic [15:0] DWELL_LAST = 16'(DWELL - 1);
  rltm_state_all_t s_q, s_d;
  logic wr_ok, rd_ok, link_up_s, eed_s;
  logic [7:0] tx_x, lnk_x, rx_x;
  logic [2:0] x_start;
  logic test_code_ok;
  assign link_up_s = s_q.link_s[1];
  assign eed_s = s_q.eed_s[1];
  // Slave port exists only when the EEPROM did not switch it off
  assign wr_ok = req.en && req.wr && !s_q.slave_off;
  assign rd_ok = req.en && !req.wr && !s_q.slave_off;
  assign test_code_ok = (s_q.shadow.test_code == `RLTM_CODE_SINGLE) ||
                        (s_q.shadow.test_code == `RLTM_CODE_SWEEP);
  // Transfer-update registers; receiver slot governs receiver registers other than mode
  rltm_xfer_slot u_tx_slot (
    .clk(clk),
    .reset(reset),
    .wr_en(wr_ok && req.addr == `RLTM_OFS_TX_XFER),
    .wdata(req.wdata),
    .done_ok(link_done_ok),
    .done_fail(link_done_fail),
    .value(tx_x),
    .start(x_start[0])
  );
  rltm_xfer_slot u_lnk_slot (
    .clk(clk),
    .reset(reset),
    .wr_en(wr_ok && req.addr == `RLTM_OFS_LNK_XFER),
    .wdata(req.wdata),
    .done_ok(link_done_ok),
    .done_fail(link_done_fail),
    .value(lnk_x),
    .start(x_start[1])
  );
  rltm_xfer_slot u_rx_slot (
    .clk(clk),
    .reset(reset),
    .wr_en(wr_ok && req.addr == `RLTM_OFS_RX_XFER),
    .wdata(req.wdata),
    .done_ok(link_done_ok),
    .done_fail(link_done_fail),
    .value(rx_x),
    .start(x_start[2])
  );
  // Next state of everything
  always_comb begin
    s_d = s_q;
    s_d.relink = 1'b0;
    s_d.reconf = 1'b0;
    s_d.exec_start = 1'b0;
    s_d.eed_s = {s_q.eed_s[0], eeprom_data};
    s_d.link_s = {s_q.link_s[0], link_up};
    s_d.sync_fill = {s_q.sync_fill[0], 1'b1};
    s_d.gpio_s1 = gpio_in;
    s_d.gpio_s2 = s_q.gpio_s1;
    // Strap: EEPROM status bit 6 caught once after reset; data held low aborts the read
    if (!s_q.strap_done && s_q.sync_fill[1] && (eeprom_done || !eeprom_present)) begin // Synchroniser filled first
      s_d.strap_done = 1'b1;
      s_d.slave_off = eeprom_present && eed_s && eeprom_slave_off;
    end
    // Host writes land in the shadow copy, except link mode, power, remote execute and the transfer-update registers
    if (wr_ok) begin
      case (req.addr)
        `RLTM_OFS_TEST_CODE: begin
          if (!s_q.test_latched) s_d.shadow.test_code = req.wdata;
        end
        `RLTM_OFS_TEST_CHAN: begin
          if (!s_q.test_latched) s_d.shadow.test_chan = req.wdata;
        end
        `RLTM_OFS_LINK_MODE: begin
          s_d.link_mode = req.wdata & ~(8'h01 << `RLTM_BIT_FORCE_RECONF);
        end
        `RLTM_OFS_POWER: begin
          s_d.power = req.wdata;
        end
        `RLTM_OFS_REMOTE_EXEC: begin
          s_d.exec_wdata = req.wdata;
          s_d.exec_start = 1'b1;
        end
        8'h00: s_d.shadow.tx_status = req.wdata;
        8'h01: s_d.shadow.tx_format = req.wdata;
        8'h02: s_d.shadow.tx_mode = req.wdata;
        8'h03: s_d.shadow.i2s_in = req.wdata;
        8'h04: s_d.shadow.tx_latency = req.wdata;
        8'h05: s_d.shadow.rx_mode = req.wdata;
        8'h06: s_d.shadow.i2s_out = req.wdata;
        // Link address bytes and channel counts
        `RLTM_OFS_ADDR_BYTE_0: s_d.addr_shadow[0] = req.wdata;
        `RLTM_OFS_ADDR_BYTE_1: s_d.addr_shadow[1] = req.wdata;
        `RLTM_OFS_ADDR_BYTE_2: s_d.addr_shadow[2] = req.wdata;
        `RLTM_OFS_ADDR_BYTE_3: s_d.addr_shadow[3] = req.wdata;
        `RLTM_OFS_ADDR_BYTE_4: s_d.addr_shadow[4] = req.wdata;
        `RLTM_OFS_HOP_COUNT: s_d.hop_cnt_shadow = req.wdata;
        `RLTM_OFS_ACT_COUNT: s_d.act_cnt_shadow = req.wdata;
        default: s_d.shadow = s_q.shadow;
      endcase
    end
    if (remote_rvalid) s_d.remote_rd = remote_rdata;
    // Register readback; test registers are write-only and read zero
    s_d.rdata = 8'h00;
    if (rd_ok) begin
      case (req.addr)
        `RLTM_OFS_TX_XFER: s_d.rdata = tx_x;
        `RLTM_OFS_LNK_XFER: s_d.rdata = lnk_x;
        `RLTM_OFS_RX_XFER: s_d.rdata = rx_x;
        `RLTM_OFS_LINK_MODE: s_d.rdata = s_q.link_mode;
        `RLTM_OFS_POWER: s_d.rdata = s_q.power;
        `RLTM_OFS_REMOTE_EXEC: s_d.rdata = s_q.remote_rd;
        `RLTM_OFS_STATUS: s_d.rdata = {3'h0, s_q.st};
        // Applied link settings read back, so deferral is visible to the host
        `RLTM_OFS_ADDR_BYTE_0: s_d.rdata = s_q.addr_live[0];
        `RLTM_OFS_ADDR_BYTE_1: s_d.rdata = s_q.addr_live[1];
        `RLTM_OFS_ADDR_BYTE_2: s_d.rdata = s_q.addr_live[2];
        `RLTM_OFS_ADDR_BYTE_3: s_d.rdata = s_q.addr_live[3];
        `RLTM_OFS_ADDR_BYTE_4: s_d.rdata = s_q.addr_live[4];
        `RLTM_OFS_HOP_COUNT: s_d.rdata = s_q.hop_cnt_live;
        `RLTM_OFS_ACT_COUNT: s_d.rdata = s_q.act_cnt_live;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Link and test state machine
    case (s_q.st)
      RLTM_ST_LOCATE: begin
        if (link_up_s) begin
          s_d.live = s_q.shadow;
          s_d.reconf = 1'b1;
          s_d.st = RLTM_ST_STREAM;
        end
      end
      RLTM_ST_STREAM: begin
        if (!link_up_s) s_d.st = RLTM_ST_LOCATE;
      end
      RLTM_ST_RELINK: begin
        s_d.relink = 1'b1;
        if (!link_up_s) s_d.st = RLTM_ST_LOCATE;
      end
      RLTM_ST_TEST: begin
        s_d.rf_power = `RLTM_POWER_TEST;
        if (s_q.live.test_code == `RLTM_CODE_SWEEP) begin
          if (s_q.dwell == DWELL_LAST) begin
            s_d.dwell = 16'h0000;
            s_d.chan = (s_q.chan == `RLTM_SWEEP_LAST) ? 7'h00 : s_q.chan + 7'h01;
          end else begin
            s_d.dwell = s_q.dwell + 16'h0001;
          end
        end else begin
          s_d.chan = s_q.live.test_chan[6:0];
        end
      end
      RLTM_ST_HOLD: s_d.st = RLTM_ST_LOCATE;
      default: s_d.st = RLTM_ST_LOCATE;
    endcase
    // Force bit: enter test mode with a valid code, otherwise relink
    if (wr_ok && req.addr == `RLTM_OFS_LINK_MODE && req.wdata[`RLTM_BIT_FORCE_RECONF] &&
        !s_q.test_latched) begin
      if (test_code_ok) begin
        s_d.test_latched = 1'b1;
        s_d.live = s_q.shadow;
        s_d.chan = 7'h00;
        s_d.dwell = 16'h0000;
        s_d.reconf = 1'b1;
        s_d.st = RLTM_ST_TEST;
      end else begin
        s_d.st = RLTM_ST_RELINK;
      end
    end
    // Link address and channel counts follow every reconfiguration
    if (s_d.reconf) begin
      s_d.addr_live = s_q.addr_shadow;
      s_d.hop_cnt_live = s_q.hop_cnt_shadow;
      s_d.act_cnt_live = s_q.act_cnt_shadow;
    end
    if (s_q.st != RLTM_ST_TEST) s_d.rf_power = s_q.power[1:0];
    // Automatic exchange: locate info from transmitter, pin state from receiver
    s_d.locate = is_transmitter && s_q.st == RLTM_ST_LOCATE;
    s_d.gpio_valid = !is_transmitter && (s_q.st == RLTM_ST_LOCATE || s_q.st == RLTM_ST_STREAM);
    s_d.gpio_out = s_q.gpio_s2;
  end
  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= RLTM_ST_HOLD;
    end else begin
      s_q <= s_d;
    end
  end
  // Registered output drive; hop table has no path to the link
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xfer_slot_start <= 3'h0;
      xfer_start <= 2'h0;
      slave_enable <= 1'b1;
      test_sweep <= 1'b0;
      send_sample_rate <= 8'h00;
    end else begin
      xfer_slot_start <= x_start;
      xfer_start <= {x_start[2], x_start[0] | x_start[1]};
      slave_enable <= !s_d.slave_off;
      test_sweep <= s_d.test_latched && s_d.live.test_code == `RLTM_CODE_SWEEP;
      send_sample_rate <= sample_rate;
    end
  end
  assign rdata = s_q.rdata;
  assign relink_req = s_q.relink;
  assign reconfig_pulse = s_q.reconf;
  assign test_active = s_q.test_latched;
  assign test_tx_dir = s_q.live.test_chan[`RLTM_BIT_TEST_DIR];
  assign rf_channel = s_q.chan;
  assign rf_power = s_q.rf_power;
  assign send_rx_mode = s_q.live.rx_mode;
  assign send_locate_info = s_q.locate;
  assign send_gpio_state = s_q.gpio_out;
  assign send_gpio_valid = s_q.gpio_valid;
  assign remote_exec_wdata = s_q.exec_wdata;
  assign remote_exec_start = s_q.exec_start;
  assign live_rx_mode = s_q.live.rx_mode;
  assign live_i2s_out = s_q.live.i2s_out;
  assign live_tx_format = s_q.live.tx_format;
  AST_TEST_STICKY: assert property (@(posedge clk) disable iff (reset)
    s_q.test_latched |=> s_q.test_latched)
    else $error("test mode left without reset");
  AST_TEST_POWER: assert property (@(posedge clk) disable iff (reset)
    s_q.st == RLTM_ST_TEST |=> rf_power == `RLTM_POWER_TEST)
    else $error("test power not forced");
  AST_LIVE_HOLD: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == RLTM_ST_STREAM && !s_d.reconf) |=> $stable(s_q.live))
    else $error("live settings changed without reconfiguration");
  AST_RECONF_ON_LINK: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == RLTM_ST_LOCATE && link_up_s) |=> reconfig_pulse && s_q.st == RLTM_ST_STREAM)
    else $error("no reconfiguration on link");
  AST_BAD_CODE_RELINK: assert property (@(posedge clk) disable iff (reset)
    (wr_ok && req.addr == `RLTM_OFS_LINK_MODE && req.wdata[4] && !test_code_ok && !s_q.test_latched)
    |=> s_q.st == RLTM_ST_RELINK ##1 relink_req)
    else $error("invalid code did not relink");
  AST_SWEEP_WRAP: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == RLTM_ST_TEST) |-> s_q.chan <= `RLTM_SWEEP_LAST)
    else $error("sweep channel out of band");
  AST_SLAVE_BLOCK: assert property (@(posedge clk) disable iff (reset)
    (s_q.slave_off && req.en && req.wr && req.addr == `RLTM_OFS_TEST_CODE) |=> $stable(s_q.shadow))
    else $error("test register written with slave port off");
  AST_GPIO_SEND: assert property (@(posedge clk) disable iff (reset)
    (!is_transmitter && s_q.st == RLTM_ST_STREAM) |=> send_gpio_valid)
    else $error("pin state not sent while streaming");
  // Guards on locate exchange, strap abort, deferral and slave port blocking
  AST_LOCATE_INFO: assert property (@(posedge clk) disable iff (reset)
    (is_transmitter && s_q.st == RLTM_ST_LOCATE) |=> send_locate_info)
    else $error("locate information not sent");
  AST_STRAP_ABORT: assert property (@(posedge clk) disable iff (reset)
    (!s_q.strap_done && s_q.sync_fill[1] && eeprom_done && !eed_s) |=> !s_q.slave_off)
    else $error("slave port off although EEPROM read aborted");
  AST_DEFER_ADDR: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == RLTM_ST_STREAM && !s_d.reconf) |=> $stable(s_q.addr_live))
    else $error("link address changed without reconfiguration");
  AST_SLAVE_READ: assert property (@(posedge clk) disable iff (reset)
    (s_q.slave_off && req.en && !req.wr) |=> rdata == 8'h00)
    else $error("register read with slave port off");
  COV_TEST: cover property (@(posedge clk) disable iff (reset) s_q.st == RLTM_ST_TEST);
  COV_RELINK: cover property (@(posedge clk) disable iff (reset) s_q.st == RLTM_ST_RELINK);
  COV_STREAM: cover property (@(posedge clk) disable iff (reset) s_q.st == RLTM_ST_STREAM);
  COV_SWEEP_TOP: cover property (@(posedge clk) disable iff (reset)
    s_q.st == RLTM_ST_TEST && s_q.chan == `RLTM_SWEEP_LAST);
  COV_SLAVE_OFF: cover property (@(posedge clk) disable iff (reset) s_q.slave_off);
endmodule
`default_nettype wire

// ===== sim/rltm_host_model.sv
// Host model that issues single-cycle register requests on the slave port
`timescale 1ns/1ns
`default_nettype none
module rltm_host_model
  import rltm_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output var rltm_req_t req
);
  initial req = '0;
  // One access: drive after a falling edge, hold across the taking edge, then release
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rd);
    @(negedge clk);
    req <= '{en: 1'h1, wr: wr, addr: addr, wdata: wdata};
    @(negedge clk);
    rd = rdata;
    req <= '{en: 1'h0, wr: 1'h0, addr: ~addr, wdata: ~wdata}; // Released lines show no stale value
  endtask
  // Writes carry the relink, test entry and transfer request codes
  task automatic write(input logic [7:0] addr, input logic [7:0] wdata);
    logic [7:0] unused;
    access(1'h1, addr, wdata, unused);
  endtask
  task automatic read(input logic [7:0] addr, output logic [7:0] rd);
    access(1'h0, addr, 8'h00, rd);
  endtask
endmodule
`default_nettype wire

// ===== sim/relink_and_test_mode_ctrl_test.sv
// Self-checking bench for the relink and test mode controller
`timescale 1ns/1ns
`default_nettype none
`include "rltm_cfg.svh"
module relink_and_test_mode_ctrl_test
  import rltm_pkg::*;
;
  logic clk, reset, is_tx, ee_present, ee_data, ee_off, ee_done, link_up, done_ok, done_fail;
  logic [3:0] gpio;
  logic [7:0] rdata, rd, exec_data;
  rltm_req_t req;
  logic slave_enable, relink_req, reconfig_pulse, test_active, test_tx_dir, test_sweep;
  logic [6:0] rf_channel, prev, top;
  logic [1:0] rf_power;
  logic [7:0] send_sample_rate, exec_wdata, live_rx_mode;
  logic send_locate_info, send_gpio_valid, exec_start, seen_relink, seen_reconf, seen_exec;
  logic [3:0] send_gpio_state;
  logic [7:0] rx_mode_out, i2s_live, fmt_live, rem_data;
  logic [2:0] xss, slot_seen;
  logic [1:0] xs, xs_seen;
  logic rem_valid;
  int fails, samples_checked, wraps, bad;
  // Transfer-update rows: offset, action (0 write 0x01, 1 done ok, 2 done fail), expected readback
  localparam logic [17:0] rows [12] = '{
    {8'h5B, 2'h0, 8'h01}, {8'h5B, 2'h1, 8'h00}, {8'h5B, 2'h0, 8'h01}, {8'h5B, 2'h2, 8'h02},
    {8'h3E, 2'h0, 8'h01}, {8'h3E, 2'h1, 8'h00}, {8'h3E, 2'h0, 8'h01}, {8'h3E, 2'h2, 8'h02},
    {8'h4B, 2'h0, 8'h01}, {8'h4B, 2'h1, 8'h00}, {8'h4B, 2'h0, 8'h01}, {8'h4B, 2'h2, 8'h02}};

  rltm_ctrl #(.DWELL(2)) DUT (
    .clk(clk), .reset(reset), .is_transmitter(is_tx), .eeprom_present(ee_present), .eeprom_data(ee_data),
    .eeprom_slave_off(ee_off), .eeprom_done(ee_done), .link_up(link_up), .link_done_ok(done_ok),
    .link_done_fail(done_fail), .gpio_in(gpio), .sample_rate(8'h44), .req(req), .remote_rdata(rem_data),
    .remote_rvalid(rem_valid), .rdata(rdata), .slave_enable(slave_enable), .relink_req(relink_req),
    .reconfig_pulse(reconfig_pulse), .test_active(test_active), .test_tx_dir(test_tx_dir),
    .test_sweep(test_sweep), .rf_channel(rf_channel), .rf_power(rf_power), .send_sample_rate(send_sample_rate),
    .send_rx_mode(rx_mode_out), .send_locate_info(send_locate_info), .send_gpio_state(send_gpio_state),
    .send_gpio_valid(send_gpio_valid), .remote_exec_wdata(exec_wdata), .remote_exec_start(exec_start),
    .xfer_start(xs), .xfer_slot_start(xss), .live_rx_mode(live_rx_mode), .live_i2s_out(i2s_live),
    .live_tx_format(fmt_live));

  rltm_host_model u_host (.clk(clk), .rdata(rdata), .req(req));

  // Clock at 100 ns period
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Catch short pulses that may fall between the bench's sampling points
  always @(posedge clk) begin
    if (relink_req === 1'h1) seen_relink <= 1'h1;
    if (reconfig_pulse === 1'h1) seen_reconf <= 1'h1;
    slot_seen <= slot_seen | xss;
    xs_seen <= xs_seen | xs;
    if (exec_start === 1'h1) begin
      seen_exec <= 1'h1;
      exec_data <= exec_wdata;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge clk);
    reset = 1'h1;
    repeat (12) @(negedge clk);
    reset = 1'h0;
    repeat (6) @(negedge clk);
  endtask

  task automatic pulse(input logic [1:0] act);
    @(negedge clk);
    done_ok = (act == 2'h1);
    done_fail = (act == 2'h2);
    @(negedge clk);
    done_ok = 1'h0;
    done_fail = 1'h0;
  endtask

  task automatic enter_test(input logic [7:0] code, input logic [7:0] chan);
    u_host.write(`RLTM_OFS_TEST_CODE, code);
    u_host.write(`RLTM_OFS_TEST_CHAN, chan);
    u_host.write(`RLTM_OFS_LINK_MODE, 8'h10);
    repeat (2) @(negedge clk);
  endtask

  // Watchdog far beyond the expected run length
  initial begin
    #1000000;
    fails++;
    stop_test();
  end

  initial begin
    {reset, is_tx, ee_present, ee_data, ee_off, ee_done} = 6'h3B;
    {link_up, done_ok, done_fail, seen_relink, seen_reconf, seen_exec} = 6'h00;
    {slot_seen, xs_seen, rem_valid, rem_data} = 14'h0000;
    gpio = 4'h0;
    fails = 0;
    samples_checked = 0;
    do_reset();
    check({7'h00, slave_enable}, 8'h01);
    check({7'h00, test_active}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      if (rows[i][9:8] == 2'h0) u_host.write(rows[i][17:10], 8'h01);
      else pulse(rows[i][9:8]);
      u_host.read(rows[i][17:10], rd);
      check(rd, rows[i][7:0]);
    end
    check({3'h0, xs_seen, slot_seen}, 8'h1F);
    $display("test transfer update done");
    u_host.write(8'h05, 8'h5A);
    u_host.write(`RLTM_OFS_POWER, 8'h01);
    u_host.write(8'h06, 8'h3C);
    u_host.write(8'h01, 8'hE1);
    u_host.write(`RLTM_OFS_ADDR_BYTE_0, 8'hA5);
    u_host.read(`RLTM_OFS_ADDR_BYTE_0, rd);
    check(rd, 8'h00);
    check(live_rx_mode, 8'h00);
    check({6'h00, rf_power}, 8'h01);
    u_host.write(`RLTM_OFS_LINK_MODE, 8'h10);
    repeat (4) @(negedge clk);
    check({7'h00, seen_relink}, 8'h01);
    check({7'h00, test_active}, 8'h00);
    check({7'h00, send_locate_info}, 8'h01);
    check(send_sample_rate, 8'h44);
    link_up = 1'h1;
    repeat (8) @(negedge clk);
    check({7'h00, seen_reconf}, 8'h01);
    check(live_rx_mode, 8'h5A);
    check({7'h00, send_locate_info}, 8'h00);
    check(rx_mode_out, 8'h5A);
    check(i2s_live, 8'h3C);
    check(fmt_live, 8'hE1);
    u_host.read(`RLTM_OFS_ADDR_BYTE_0, rd);
    check(rd, 8'hA5);
    u_host.write(`RLTM_OFS_REMOTE_EXEC, 8'hC3);
    repeat (2) @(negedge clk);
    check({7'h00, seen_exec}, 8'h01);
    check(exec_data, 8'hC3);
    @(negedge clk);
    {rem_valid, rem_data} = 9'h196;
    @(negedge clk);
    rem_valid = 1'h0;
    u_host.read(`RLTM_OFS_REMOTE_EXEC, rd);
    check(rd, 8'h96);
    $display("test relink done");
    enter_test(`RLTM_CODE_SINGLE, 8'h85);
    check({6'h00, test_active, test_sweep}, 8'h02);
    check({7'h00, test_tx_dir}, 8'h01);
    check({1'h0, rf_channel}, 8'h05);
    check({6'h00, rf_power}, 8'h03);
    enter_test(`RLTM_CODE_SWEEP, 8'h09);
    check({6'h00, test_active, test_sweep}, 8'h02);
    check({1'h0, rf_channel}, 8'h05);
    link_up = 1'h0;
    do_reset();
    check({7'h00, test_active}, 8'h00);
    $display("test single channel done");
    enter_test(`RLTM_CODE_SWEEP, 8'h00);
    check({6'h00, test_active, test_sweep}, 8'h03);
    check({7'h00, test_tx_dir}, 8'h00);
    prev = rf_channel;
    top = 7'h00;
    wraps = 0;
    bad = 0;
    repeat (400) begin
      @(negedge clk);
      if (rf_channel !== prev) begin
        if (rf_channel === 7'h00 && prev === 7'h50) wraps++;
        else if (rf_channel !== prev + 7'h01) bad++;
      end
      if (rf_channel > top) top = rf_channel;
      prev = rf_channel;
    end
    check({1'h0, top}, 8'h50);
    check({7'h00, wraps > 0}, 8'h01);
    check(bad[7:0], 8'h00);
    $display("test sweep done");
    {is_tx, ee_data, gpio} = 6'h1A;
    do_reset();
    check({7'h00, slave_enable}, 8'h00);
    check({3'h0, send_gpio_valid, send_gpio_state}, 8'h1A);
    enter_test(`RLTM_CODE_SINGLE, 8'h85);
    check({7'h00, test_active}, 8'h00);
    u_host.read(`RLTM_OFS_STATUS, rd);
    check(rd, 8'h00);
    ee_data = 1'h0;
    do_reset();
    check({7'h00, slave_enable}, 8'h01);
    link_up = 1'h1;
    repeat (6) @(negedge clk);
    check({7'h00, send_gpio_valid}, 8'h01);
    $display("test receiver strap done");
    stop_test();
  end
endmodule
`default_nettype wire
